/* File: hdl/tpg_pkg.sv */
// tpg_pkg: constants of the three-pin gpio port
// assumes: included before every other design file
package tpg_pkg;

  // ----------------------------------------
  // widths
  // ----------------------------------------
  localparam int PIN_N = 3;     // port pins
  localparam int ADDR_W = 8;    // bus address bits
  localparam int DATA_W = 32;   // bus data bits

  // ----------------------------------------
  // register byte offsets
  // ----------------------------------------
  localparam logic [7:0] OFF_DATA = 8'h00;  // port_data_latch
  localparam logic [7:0] OFF_DIR = 8'h04;   // port_direction
  localparam logic [7:0] OFF_PULL = 8'h08;  // port_pullup_enable
  localparam logic [7:0] OFF_STBY = 8'h0C;  // standby pin control
  localparam logic [7:0] OFF_RMW = 8'h10;   // latch read-back view

  // ----------------------------------------
  // fields and reset values
  // ----------------------------------------
  localparam int SPL_BIT = 0;                 // standby_pin_state_control
  localparam int TMR_OUT_PIN = 0;             // reload_timer_output pin
  localparam int TMR_IN_PIN = 1;              // reload_timer_input pin
  localparam logic [2:0] LATCH_RST = 3'h0;    // latch after reset
  localparam logic [2:0] DIR_RST = 3'h0;      // all pins input
  localparam logic [2:0] PULL_RST = 3'h0;     // pull-ups off
  localparam logic SPL_RST = 1'b0;            // standby keeps state
  localparam logic [2:0] ALL_OFF = 3'h7;      // all drivers released

  // ----------------------------------------
  // bus responses
  // ----------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

/* File: hdl/tpg_reg_if.sv */
// tpg_reg_if: register access strobes between bus slave and port
// assumes: both ends on core_clk
`timescale 1ns/1ps
interface tpg_reg_if;
  logic wrEn;          // one-cycle write strobe
  logic [7:0] wrAddr;  // write byte address
  logic [31:0] wrData; // write data
  logic [3:0] wrStrb;  // byte strobes
  logic wrOk;          // address mapped
  logic rdEn;          // one-cycle read strobe
  logic [7:0] rdAddr;  // read byte address
  logic [31:0] rdData; // read data, same cycle
  logic rdOk;          // address mapped

  // bus side
  modport slave(output wrEn, wrAddr, wrData, wrStrb, rdEn, rdAddr,
                input wrOk, rdData, rdOk);
  // register side
  modport regs(input wrEn, wrAddr, wrData, wrStrb, rdEn, rdAddr,
               output wrOk, rdData, rdOk);
endinterface

/* File: hdl/tpg_axil_slave.sv */
// tpg_axil_slave: axi4-lite slave front end for the port registers
// assumes: one clock, synchronous active-low reset
`timescale 1ns/1ps
module tpg_axil_slave (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // write address and data
  input wire logic [tpg_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [tpg_pkg::DATA_W-1:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // read
  input wire logic [tpg_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [tpg_pkg::DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // register side
  tpg_reg_if.slave regIf
);
  import tpg_pkg::*;

  logic awHeld, next_awHeld;        // address captured
  logic wHeld, next_wHeld;          // data captured
  logic [7:0] addrQ, next_addrQ;    // held write address
  logic [31:0] dataQ, next_dataQ;   // held write data
  logic [3:0] strbQ, next_strbQ;    // held strobes
  logic next_awready, next_wready;
  logic next_bvalid, next_arready, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata;

  // ----------------------------------------
  // write and read channel next state
  // ----------------------------------------
  always_comb begin
    next_awHeld = awHeld;
    next_wHeld = wHeld;
    next_addrQ = addrQ;
    next_dataQ = dataQ;
    next_strbQ = strbQ;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_arready = arready;
    next_rvalid = rvalid;
    next_rresp = rresp;
    next_rdata = rdata;
    // both halves held: fire the write
    regIf.wrEn = awHeld && wHeld;
    regIf.wrAddr = addrQ;
    regIf.wrData = dataQ;
    regIf.wrStrb = strbQ;
    regIf.rdEn = arvalid && arready;
    regIf.rdAddr = araddr;
    if (awvalid && awready) begin
      next_awHeld = 1'b1;
      next_addrQ = awaddr;
    end
    if (wvalid && wready) begin
      next_wHeld = 1'b1;
      next_dataQ = wdata;
      next_strbQ = wstrb;
    end
    if (regIf.wrEn) begin
      next_awHeld = 1'b0;
      next_wHeld = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = regIf.wrOk ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid && bready) begin
      next_bvalid = 1'b0;
    end
    // one write in flight at a time
    next_awready = !next_awHeld && !next_bvalid && !regIf.wrEn;
    next_wready = !next_wHeld && !next_bvalid && !regIf.wrEn;
    // read: answer data the edge after the address
    if (regIf.rdEn) begin
      next_arready = 1'b0;
      next_rvalid = 1'b1;
      next_rdata = regIf.rdOk ? regIf.rdData : '0;
      next_rresp = regIf.rdOk ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid && rready) begin
      next_rvalid = 1'b0;
      next_arready = 1'b1;
    end
  end

  // ----------------------------------------
  // channel registers
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      addrQ <= 8'h00;
      dataQ <= 32'h0000_0000;
      strbQ <= 4'h0;
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= 2'h0;
      arready <= 1'b1;
      rvalid <= 1'b0;
      rresp <= 2'h0;
      rdata <= 32'h0000_0000;
    end else begin
      awHeld <= next_awHeld;
      wHeld <= next_wHeld;
      addrQ <= next_addrQ;
      dataQ <= next_dataQ;
      strbQ <= next_strbQ;
      awready <= next_awready;
      wready <= next_wready;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      arready <= next_arready;
      rvalid <= next_rvalid;
      rresp <= next_rresp;
      rdata <= next_rdata;
    end
  end
endmodule

/* File: hdl/tpg_gpio_port.sv */
// tpg_gpio_port: three-pin general purpose port with shared timer pins
// assumes: core_clk 200 MHz, pads sampled from outside, standby and
// timer signals come from logic on core_clk
`timescale 1ns/1ps
module tpg_gpio_port (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // axi4-lite write address
  input wire logic [tpg_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [tpg_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [tpg_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [tpg_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // port pins, bit n is port_pin_n
  input wire logic [tpg_pkg::PIN_N-1:0] padIn,
  output logic [tpg_pkg::PIN_N-1:0] padOut,
  output logic [tpg_pkg::PIN_N-1:0] padOe_b,
  output logic [tpg_pkg::PIN_N-1:0] padPullup,
  // reload timer
  input wire logic timerOutEn,
  input wire logic reloadTimerOutput,
  output logic reloadTimerInput,
  // power control: stop or watch mode active
  input wire logic stopWatchMode
);
  import tpg_pkg::*;

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  tpg_reg_if regIf ();                    // bus to register strobes

  logic [PIN_N-1:0] portDataLatch;        // output latch
  logic [PIN_N-1:0] portDirection;        // 1 = output
  logic [PIN_N-1:0] portPullupEnable;     // 1 = pull-up wanted
  logic standbyPinStateControl;           // hi-z in stop/watch
  logic [PIN_N-1:0] next_portDataLatch;
  logic [PIN_N-1:0] next_portDirection;
  logic [PIN_N-1:0] next_portPullupEnable;
  logic next_standbyPinStateControl;

  logic [PIN_N-1:0] padMeta;              // first sync stage
  logic [PIN_N-1:0] padSync;              // second sync stage

  logic hiZ;                              // forced standby hi-z
  logic [PIN_N-1:0] sensed;               // gated pin level
  logic [PIN_N-1:0] drvEn;                // driver on, per pin
  logic [PIN_N-1:0] drvVal;               // driven level, per pin
  logic [PIN_N-1:0] next_padOut;
  logic [PIN_N-1:0] next_padOe_b;
  logic [PIN_N-1:0] next_padPullup;
  logic next_reloadTimerInput;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // widen a pin vector into a bus word, upper bits zero
  function automatic logic [DATA_W-1:0] toWord(input logic [PIN_N-1:0] v);
    toWord = {{(DATA_W-PIN_N){1'b0}}, v};
  endfunction

  // write hits a given register with its low byte enabled
  function automatic logic hitWr(input logic [7:0] off);
    hitWr = regIf.wrEn && regIf.wrStrb[0] && (regIf.wrAddr == off);
  endfunction

  // ----------------------------------------
  // bus slave
  // ----------------------------------------
  tpg_axil_slave uSlave (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .awaddr(s_axi_awaddr),
    .awvalid(s_axi_awvalid),
    .awready(s_axi_awready),
    .wdata(s_axi_wdata),
    .wstrb(s_axi_wstrb),
    .wvalid(s_axi_wvalid),
    .wready(s_axi_wready),
    .bresp(s_axi_bresp),
    .bvalid(s_axi_bvalid),
    .bready(s_axi_bready),
    .araddr(s_axi_araddr),
    .arvalid(s_axi_arvalid),
    .arready(s_axi_arready),
    .rdata(s_axi_rdata),
    .rresp(s_axi_rresp),
    .rvalid(s_axi_rvalid),
    .rready(s_axi_rready),
    .regIf(regIf.slave)
  );

  // ----------------------------------------
  // register writes
  // ----------------------------------------
  // latch is stored whatever the direction
  always_comb begin
    next_portDataLatch = portDataLatch;
    next_portDirection = portDirection;
    next_portPullupEnable = portPullupEnable;
    next_standbyPinStateControl = standbyPinStateControl;
    regIf.wrOk = 1'b1;
    // only bits 0..2 are stored
    if (hitWr(OFF_DATA)) begin
      next_portDataLatch = regIf.wrData[PIN_N-1:0];
    end
    if (hitWr(OFF_DIR)) begin
      next_portDirection = regIf.wrData[PIN_N-1:0];
    end
    if (hitWr(OFF_PULL)) begin
      next_portPullupEnable = regIf.wrData[PIN_N-1:0];
    end
    if (hitWr(OFF_STBY)) begin
      next_standbyPinStateControl = regIf.wrData[SPL_BIT];
    end
    // read-back view is not writable
    unique case (regIf.wrAddr)
      OFF_DATA, OFF_DIR, OFF_PULL, OFF_STBY: regIf.wrOk = 1'b1;
      default: regIf.wrOk = 1'b0;
    endcase
  end

  // register file; direction cleared at reset
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      portDataLatch <= LATCH_RST;
      portDirection <= DIR_RST;
      portPullupEnable <= PULL_RST;
      standbyPinStateControl <= SPL_RST;
    end else begin
      portDataLatch <= next_portDataLatch;
      portDirection <= next_portDirection;
      portPullupEnable <= next_portPullupEnable;
      standbyPinStateControl <= next_standbyPinStateControl;
    end
  end

  // ----------------------------------------
  // pad input synchroniser
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      padMeta <= 3'h0;
      padSync <= 3'h0;
    end else begin
      padMeta <= padIn;
      padSync <= padMeta;
    end
  end

  // ----------------------------------------
  // standby gating and input path
  // ----------------------------------------
  // hi-z only when control set and in stop/watch
  assign hiZ = standbyPinStateControl && stopWatchMode;
  // input held low while blocked
  assign sensed = hiZ ? 3'h0 : padSync;

  // ----------------------------------------
  // pin drive selection
  // ----------------------------------------
  always_comb begin
    // port function: direction picks latch or release
    drvEn = portDirection;
    drvVal = portDataLatch;
    // timer output wins over port
    if (timerOutEn) begin
      drvEn[TMR_OUT_PIN] = 1'b1;
      drvVal[TMR_OUT_PIN] = reloadTimerOutput;
    end
    // standby override releases every driver
    if (hiZ) begin
      drvEn = 3'h0;
    end
  end

  // pad outputs; enable is active low
  always_comb begin
    next_padOut = drvVal;
    next_padOe_b = ~drvEn;
    // pull-up dropped while driving low
    next_padPullup = portPullupEnable & ~(drvEn & ~drvVal);
    // timer input taken from the pin level whatever the
    // direction; software sets it input first
    next_reloadTimerInput = sensed[TMR_IN_PIN];
  end

  // registered pad and timer outputs
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      padOut <= 3'h0;
      padOe_b <= ALL_OFF;
      padPullup <= 3'h0;
      reloadTimerInput <= 1'b0;
    end else begin
      padOut <= next_padOut;
      padOe_b <= next_padOe_b;
      padPullup <= next_padPullup;
      reloadTimerInput <= next_reloadTimerInput;
    end
  end

  // ----------------------------------------
  // register reads
  // ----------------------------------------
  always_comb begin
    regIf.rdOk = 1'b1;
    regIf.rdData = '0;
    unique case (regIf.rdAddr)
      // port output gives latch, else pin level
      // the timer output pin reads the pin level, except in standby hi-z
      OFF_DATA: regIf.rdData = toWord(
        (portDirection & ~({2'b00, timerOutEn} & ~{3{hiZ}}))
        & portDataLatch
        | ~(portDirection & ~({2'b00, timerOutEn} & ~{3{hiZ}})) & sensed);
      // latch view for read-modify-write
      OFF_RMW: regIf.rdData = toWord(portDataLatch);
      OFF_DIR: regIf.rdData = toWord(portDirection);
      OFF_PULL: regIf.rdData = toWord(portPullupEnable);
      OFF_STBY: regIf.rdData = toWord({2'b00, standbyPinStateControl});
      default: regIf.rdOk = 1'b0;
    endcase
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  property p_dirRst;
    @(posedge core_clk) disable iff (!rst_b)
      $rose(rst_b) |-> (portDirection == 3'h0) && (padOe_b == 3'h7);
  endproperty
  a_dirRst: assert property (p_dirRst)
    else $error("direction not cleared by reset");

  property p_outDrive;
    @(posedge core_clk) disable iff (!rst_b)
      (portDirection[2] && !hiZ) |=>
        (!padOe_b[2] && padOut[2] == $past(portDataLatch[2]));
  endproperty
  a_outDrive: assert property (p_outDrive)
    else $error("output pin not driving latch");

  property p_inRelease;
    @(posedge core_clk) disable iff (!rst_b)
      (!portDirection[1]) |=> padOe_b[1];
  endproperty
  a_inRelease: assert property (p_inRelease)
    else $error("input pin driver enabled");

  property p_hiZ;
    @(posedge core_clk) disable iff (!rst_b)
      (standbyPinStateControl && stopWatchMode) |=>
        (padOe_b == 3'h7) && !reloadTimerInput;
  endproperty
  a_hiZ: assert property (p_hiZ)
    else $error("standby hi-z not forced");

  property p_keep;
    @(posedge core_clk) disable iff (!rst_b)
      (!standbyPinStateControl && stopWatchMode && portDirection[2])
        |=> !padOe_b[2];
  endproperty
  a_keep: assert property (p_keep)
    else $error("pin state lost in standby");

  property p_timerOut;
    @(posedge core_clk) disable iff (!rst_b)
      (timerOutEn && !hiZ) |=>
        (!padOe_b[0] && padOut[0] == $past(reloadTimerOutput));
  endproperty
  a_timerOut: assert property (p_timerOut)
    else $error("timer output not on pin");

  property p_pullLow;
    @(posedge core_clk) disable iff (!rst_b)
      (!padOe_b[0] && !padOut[0]) |-> !padPullup[0];
  endproperty
  a_pullLow: assert property (p_pullLow)
    else $error("pull-up on while driving low");

  property p_pullOn;
    @(posedge core_clk) disable iff (!rst_b)
      (portPullupEnable[1] && !portDirection[1]) |=> padPullup[1];
  endproperty
  a_pullOn: assert property (p_pullOn)
    else $error("pull-up not connected");

  property p_write;
    @(posedge core_clk) disable iff (!rst_b)
      (regIf.wrEn && regIf.wrStrb[0] && regIf.wrAddr == OFF_DATA) |=>
        portDataLatch == $past(regIf.wrData[2:0]);
  endproperty
  a_write: assert property (p_write)
    else $error("latch not updated by write");

  property p_readOut;
    @(posedge core_clk) disable iff (!rst_b)
      (regIf.rdEn && regIf.rdAddr == OFF_DATA && portDirection[2]) |->
        regIf.rdData[2] == portDataLatch[2];
  endproperty
  a_readOut: assert property (p_readOut)
    else $error("output pin read not latch");

  property p_readIn;
    @(posedge core_clk) disable iff (!rst_b)
      (regIf.rdEn && regIf.rdAddr == OFF_DATA && !portDirection[1]) |->
        regIf.rdData[1] == sensed[1];
  endproperty
  a_readIn: assert property (p_readIn)
    else $error("input pin read not pin level");

  property p_rmw;
    @(posedge core_clk) disable iff (!rst_b)
      (regIf.rdEn && regIf.rdAddr == OFF_RMW) |->
        regIf.rdData == toWord(portDataLatch);
  endproperty
  a_rmw: assert property (p_rmw)
    else $error("rmw view not latch");

  property p_blocked;
    @(posedge core_clk) disable iff (!rst_b)
      (regIf.rdEn && regIf.rdAddr == OFF_DATA && hiZ) |->
        regIf.rdData == toWord(portDataLatch & portDirection);
  endproperty
  a_blocked: assert property (p_blocked)
    else $error("blocked input not low");

endmodule

/* File: verification/tpg_board_model.sv */
// tpg_board_model: board circuitry seen by the three port pins
// assumes: port pad outputs plus bench-controlled external sources
`timescale 1ns/1ps
module tpg_board_model (
  // clock
  input wire logic core_clk,
  // port side
  input wire logic [tpg_pkg::PIN_N-1:0] padOut,
  input wire logic [tpg_pkg::PIN_N-1:0] padOe_b,
  input wire logic [tpg_pkg::PIN_N-1:0] padPullup,
  // external sources on the board
  input wire logic [tpg_pkg::PIN_N-1:0] extLevel,
  input wire logic [tpg_pkg::PIN_N-1:0] extEn,
  // levels sensed by the port
  output logic [tpg_pkg::PIN_N-1:0] padIn
);
  import tpg_pkg::*;
  logic floatLevel; // an undriven pin wanders every cycle
  // ----------------------------------------
  // floating pattern
  // ----------------------------------------
  initial floatLevel = 1'b0;
  always @(posedge core_clk) begin
    floatLevel <= ~floatLevel;
  end
  // ----------------------------------------
  // pin resolution, port driver first
  // ----------------------------------------
  always_comb begin
    for (int n = 0; n < PIN_N; n++) begin
      if (!padOe_b[n]) begin // port drives the pin
        padIn[n] = padOut[n];
      end else if (extEn[n]) begin // board source drives
        padIn[n] = extLevel[n];
      end else if (padPullup[n]) begin // only the pull-up
        padIn[n] = 1'b1;
      end else begin // nothing holds the pin
        padIn[n] = floatLevel;
      end
    end
  end
endmodule

/* File: verification/tpg_gpio_port_tb.sv */
// tpg_gpio_port_tb: register-level tests of the three-pin port
// assumes: board model on the pads, axi4-lite master tasks below
`timescale 1ns/1ps
module tpg_gpio_port_tb;
  import tpg_pkg::*;
  logic core_clk, rst_b; // clock and reset
  logic [7:0] awaddr, araddr; // bus addresses
  logic awvalid, awready, wvalid, wready, bvalid, bready; // write handshakes
  logic arvalid, arready, rvalid, rready; // read handshakes
  logic [31:0] wdata, rdata; // bus data
  logic [3:0] wstrb; // byte strobes
  logic [1:0] bresp, rresp; // responses
  logic [2:0] padIn, padOut, padOe_b, padPullup, extLevel, extEn; // pins
  logic timerOutEn, reloadTimerOutput, reloadTimerInput, stopWatchMode; // side
  int bad_count, checks; // tallies
  // ----------------------------------------
  // clock, design and board
  // ----------------------------------------
  always #2.5 core_clk = ~core_clk;
  tpg_gpio_port dut_u (.core_clk(core_clk), .rst_b(rst_b), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .padIn(padIn), .padOut(padOut), .padOe_b(padOe_b),
    .padPullup(padPullup), .timerOutEn(timerOutEn),
    .reloadTimerOutput(reloadTimerOutput), .reloadTimerInput(reloadTimerInput),
    .stopWatchMode(stopWatchMode));
  tpg_board_model board_u (.core_clk(core_clk), .padOut(padOut), .padOe_b(padOe_b),
    .padPullup(padPullup), .extLevel(extLevel), .extEn(extEn), .padIn(padIn));
  // ----------------------------------------
  // report helpers
  // ----------------------------------------
  task automatic finish_test();
    $display("checks %0d bad %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic timed_out();
    bad_count++;
    $display("BAD bus wait expected answer seen none");
    finish_test();
  endtask
  // ----------------------------------------
  // axi4-lite master, entered just after an edge
  // ----------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    bit done;
    n = 0;
    done = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done && n < 50) begin
      @(posedge core_clk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        done = 1;
        chk("bresp", er, bresp);
      end
    end
    if (!done) timed_out();
  endtask
  task automatic rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
    int n;
    bit done;
    n = 0;
    done = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done && n < 50) begin
      @(posedge core_clk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        done = 1;
        d = rdata;
        chk("rresp", er, rresp);
      end
    end
    if (!done) timed_out();
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, RESP_OKAY, d);
    chk($sformatf("reg %h", a), exp, d);
  endtask
  task automatic settle();
    repeat (4) @(posedge core_clk);
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    logic [31:0] d;
    core_clk = 1'b0;
    rst_b = 1'b0;
    {awaddr, araddr, wdata, wstrb} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {extLevel, extEn, timerOutEn, reloadTimerOutput, stopWatchMode} = '0;
    bad_count = 0;
    checks = 0;
    repeat (4) @(posedge core_clk);
    rst_b <= 1'b1;
    wstrb <= 4'hF;
    repeat (2) @(posedge core_clk);
    // reset state: all inputs, drivers off
    rchk(OFF_DIR, 32'h0);
    chk("padOe_b", 32'h7, padOe_b);
    $display("test reset done");
    // input pins: read gives pins, latch kept apart
    extEn <= 3'h7;
    extLevel <= 3'h5;
    wr(OFF_DATA, 32'h2, RESP_OKAY);
    settle();
    chk("padOe_b", 32'h7, padOe_b);
    rchk(OFF_DATA, 32'h5);
    rchk(OFF_RMW, 32'h2);
    chk("timer in", 32'h0, reloadTimerInput);
    extLevel <= 3'h2; // pin used as timer input
    settle();
    chk("timer in", 32'h1, reloadTimerInput);
    rchk(OFF_DATA, 32'h2);
    $display("test input done");
    // output pins: latch drives, read returns latch
    extEn <= 3'h0;
    wr(OFF_DIR, 32'h7, RESP_OKAY);
    wr(OFF_DATA, 32'hFFFF_FFF5, RESP_OKAY);
    settle();
    chk("padOe_b", 32'h0, padOe_b);
    chk("padOut", 32'h5, padOut);
    rchk(OFF_DATA, 32'h5);
    rchk(OFF_DIR, 32'h7);
    wr(OFF_DATA, 32'h3, RESP_OKAY);
    settle();
    chk("padOut", 32'h3, padOut);
    wr(OFF_DATA, 32'h5, RESP_OKAY);
    // pull-up: off while driving low
    wr(OFF_PULL, 32'h7, RESP_OKAY);
    settle();
    chk("padPullup", 32'h5, padPullup);
    rchk(OFF_PULL, 32'h7);
    wr(OFF_DIR, 32'h0, RESP_OKAY);
    settle();
    chk("padPullup", 32'h7, padPullup);
    rchk(OFF_DATA, 32'h7);
    $display("test output done");
    // timer output takes pin 0 over latch and direction
    timerOutEn <= 1'b1;
    reloadTimerOutput <= 1'b0;
    settle();
    chk("padOe_b", 32'h6, padOe_b);
    chk("padOut0", 32'h0, padOut[0]);
    chk("padPullup", 32'h6, padPullup);
    rchk(OFF_DATA, 32'h6);
    rchk(OFF_RMW, 32'h5);
    reloadTimerOutput <= 1'b1;
    settle();
    rchk(OFF_DATA, 32'h7);
    timerOutEn <= 1'b0;
    $display("test timer done");
    // standby: forced hi-z with blocked inputs, or kept state
    wr(OFF_DIR, 32'h5, RESP_OKAY); // pin 1 input, pulled high
    wr(OFF_STBY, 32'h1, RESP_OKAY);
    stopWatchMode <= 1'b1;
    settle();
    chk("padOe_b", 32'h7, padOe_b);
    rchk(OFF_DATA, 32'h5);
    chk("timer in", 32'h0, reloadTimerInput);
    wr(OFF_STBY, 32'h0, RESP_OKAY);
    settle();
    chk("padOe_b", 32'h2, padOe_b);
    chk("padOut", 32'h5, padOut);
    stopWatchMode <= 1'b0;
    $display("test standby done");
    // refused accesses
    wr(8'h20, 32'h7, RESP_SLVERR);
    rd(8'h20, RESP_SLVERR, d);
    chk("unmapped data", 32'h0, d);
    wstrb <= 4'hE; // low byte off: write leaves latch alone
    wr(OFF_DATA, 32'h0, RESP_OKAY);
    wstrb <= 4'hF;
    wr(OFF_RMW, 32'h0, RESP_SLVERR);
    rchk(OFF_RMW, 32'h5);
    $display("test errors done");
    finish_test();
  end
endmodule
